// ### src/rtcco_pkg.sv
// rtcco_pkg: constants and types shared by the slow clock output and periodic irq logic
// assumes a 100 MHz ref_clk and a 32.768 kHz crystal clock sampled as a plain input
package rtcco_pkg;

  // ----------------------------------------------------------------
  // clocking and prescaler
  // ----------------------------------------------------------------
  localparam int REF_CLK_HZ = 100000000;
  localparam int XTAL_HZ = 32768;
  localparam int PRESCALE_W = 15;
  localparam logic [14:0] PRESCALE_MAX = 15'h7FFF;
  localparam int HALF_SEC_BIT = 14;
  localparam int QUARTER_SEC_BIT = 13;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ----------------------------------------------------------------
  // control bit positions and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL1_OFFSET = 4'hE;
  localparam logic [3:0] CTRL2_OFFSET = 4'hF;
  localparam int DISABLE_A_BIT = 3;
  localparam int DISABLE_B_BIT = 4;
  localparam logic DISABLE_RESET = 1'h0;

  // ----------------------------------------------------------------
  // period select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] PSEL_OFF = 3'h0;
  localparam logic [2:0] PSEL_FIXED_LOW = 3'h1;
  localparam logic [2:0] PSEL_PULSE_2HZ = 3'h2;
  localparam logic [2:0] PSEL_PULSE_1HZ = 3'h3;
  localparam logic [2:0] PSEL_LEVEL_SEC = 3'h4;
  localparam logic [2:0] PSEL_LEVEL_MIN = 3'h5;
  localparam logic [2:0] PSEL_LEVEL_HOUR = 3'h6;
  localparam logic [2:0] PSEL_LEVEL_MONTH = 3'h7;

  typedef enum logic [1:0] {
    GATE_OFF = 2'h1,
    GATE_ON = 2'h2
  } rtcco_gate_e;

  // rollover pulses from the time counters, ref_clk domain
  typedef struct packed {
    logic minuteTick;
    logic hourTick;
    logic monthTick;
  } rtcco_events_s;

endpackage : rtcco_pkg

// ### src/rtcco_sync.sv
// rtcco_sync: two flip-flop synchroniser for a bundle of independent levels
// assumes each bit is a slow level or a clock far below ref_clk
`timescale 1ns/1ps
module rtcco_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule : rtcco_sync

// ### src/rtcco_top.sv
// rtcco_top: gated 32.768 kHz output, second prescaler, periodic irq and power-from-zero flag
// assumes ref_clk at 100 MHz; crystal clock, control pin and battery strap arrive asynchronously
// How it works
// - clock output runs when control pin high and either disable bit is zero.
// - both disable bits one or control pin low holds clock output low.
// - disable bits live at D3 of Fh and D4 of Eh, reset zero.
// - output start and stop follow the crystal low phase, no truncated pulses.
// - power-from-zero flag reads zero when power came back from battery.
// - writing the seconds counter clears the sub-second prescaler.
// - level mode pulls irq low each period until the flag is cleared.
// - top select bit chooses level mode: second, minute, hour or month.
`timescale 1ns/1ps
module rtcco_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic xtalClk,
  input wire logic clock_out_control_pin,
  input wire logic disableWrite,
  input wire logic clockOutDisableAIn,
  input wire logic clockOutDisableBIn,
  input wire logic secondsWrite,
  input wire logic [2:0] period_select,
  input wire logic periodicFlagClear,
  input wire rtcco_pkg::rtcco_events_s calEvents,
  input wire logic batteryRestored,
  input wire logic powerFlagClear,
  output logic slow_clock_output_pin,
  output logic irq_out_a,
  output logic irqOutAOe,
  output logic periodic_irq_flag,
  output logic power_from_zero_flag,
  output logic clock_out_disable_a,
  output logic clock_out_disable_b,
  output logic secondTick
);

  // ----------------------------------------------------------------
  // input synchronisation and crystal edge detection
  // ----------------------------------------------------------------
  logic [2:0] syncBus;
  logic xtalS;
  logic ctrlPinS;
  logic batteryS;
  logic xtalPrev_q;
  logic xtalRise;
  logic xtalFall;

  rtcco_sync #(
    .WIDTH(3)
  ) rtcco_sync_i (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .asyncIn({batteryRestored, clock_out_control_pin, xtalClk}),
    .syncOut(syncBus)
  );

  assign xtalS = syncBus[0];
  assign ctrlPinS = syncBus[1];
  assign batteryS = syncBus[2];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      xtalPrev_q <= 1'h0;
    end else begin
      xtalPrev_q <= xtalS;
    end
  end

  assign xtalRise = xtalS & ~xtalPrev_q;
  assign xtalFall = ~xtalS & xtalPrev_q;

  // ----------------------------------------------------------------
  // clock-out disable bits
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      clock_out_disable_a <= rtcco_pkg::DISABLE_RESET;
      clock_out_disable_b <= rtcco_pkg::DISABLE_RESET;
    end else if (disableWrite) begin
      clock_out_disable_a <= clockOutDisableAIn;
      clock_out_disable_b <= clockOutDisableBIn;
    end
  end

  // ----------------------------------------------------------------
  // clock output gate
  // ----------------------------------------------------------------
  rtcco_pkg::rtcco_gate_e gate_q;
  rtcco_pkg::rtcco_gate_e gate_d;
  logic gateWant;

  assign gateWant = ctrlPinS & ~(clock_out_disable_a & clock_out_disable_b);

  // gate moves only on a crystal falling edge, so a pulse is never cut short
  always_comb begin
    gate_d = gate_q;
    case (gate_q)
      rtcco_pkg::GATE_OFF: if (xtalFall && gateWant) gate_d = rtcco_pkg::GATE_ON;
      rtcco_pkg::GATE_ON: if (xtalFall && !gateWant) gate_d = rtcco_pkg::GATE_OFF;
      default: gate_d = rtcco_pkg::GATE_OFF;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gate_q <= rtcco_pkg::GATE_OFF;
    end else begin
      gate_q <= gate_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      slow_clock_output_pin <= 1'h0;
    end else begin
      slow_clock_output_pin <= (gate_q == rtcco_pkg::GATE_ON) & xtalS;
    end
  end

  // ----------------------------------------------------------------
  // one-second prescaler
  // ----------------------------------------------------------------
  logic [rtcco_pkg::PRESCALE_W-1:0] prescale_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prescale_q <= '0;
    end else if (secondsWrite) begin
      prescale_q <= '0;
    end else if (xtalRise) begin
      prescale_q <= prescale_q + 15'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      secondTick <= 1'h0;
    end else begin
      secondTick <= xtalRise & ~secondsWrite & (prescale_q == rtcco_pkg::PRESCALE_MAX);
    end
  end

  // ----------------------------------------------------------------
  // periodic interrupt
  // ----------------------------------------------------------------
  logic periodEvent;
  logic irqLow;

  always_comb begin
    case (period_select)
      rtcco_pkg::PSEL_LEVEL_SEC: periodEvent = secondTick;
      rtcco_pkg::PSEL_LEVEL_MIN: periodEvent = calEvents.minuteTick;
      rtcco_pkg::PSEL_LEVEL_HOUR: periodEvent = calEvents.hourTick;
      rtcco_pkg::PSEL_LEVEL_MONTH: periodEvent = calEvents.monthTick;
      default: periodEvent = 1'h0;
    endcase
  end

  // a new period arriving with the clear keeps the flag set
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      periodic_irq_flag <= 1'h0;
    end else if (periodEvent) begin
      periodic_irq_flag <= 1'h1;
    end else if (periodicFlagClear) begin
      periodic_irq_flag <= 1'h0;
    end
  end

  // pulse modes fall together with the second increment
  always_comb begin
    case (period_select)
      rtcco_pkg::PSEL_OFF: irqLow = 1'h0;
      rtcco_pkg::PSEL_FIXED_LOW: irqLow = 1'h1;
      rtcco_pkg::PSEL_PULSE_2HZ: irqLow = ~prescale_q[rtcco_pkg::QUARTER_SEC_BIT];
      rtcco_pkg::PSEL_PULSE_1HZ: irqLow = ~prescale_q[rtcco_pkg::HALF_SEC_BIT];
      default: irqLow = periodic_irq_flag;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irqOutAOe <= 1'h0;
    end else begin
      irqOutAOe <= irqLow;
    end
  end

  // open drain: only ever pulls low
  assign irq_out_a = 1'h0;

  // ----------------------------------------------------------------
  // power-from-zero flag
  // ----------------------------------------------------------------
  // strap is taken only once the synchroniser has refilled after reset
  logic [1:0] settle_q;
  logic strapTake;

  assign strapTake = (settle_q == (rtcco_pkg::STRAP_SETTLE - 2'h1));

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      settle_q <= 2'h0;
    end else if (settle_q != rtcco_pkg::STRAP_SETTLE) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      power_from_zero_flag <= 1'h0;
    end else if (strapTake) begin
      power_from_zero_flag <= ~batteryS;
    end else if (powerFlagClear) begin
      power_from_zero_flag <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_clock_runs: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (gate_q == rtcco_pkg::GATE_ON) && xtalS |=> slow_clock_output_pin)
    else $error("clock output not following crystal while gated on");

  a_clock_held_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    xtalFall && !gateWant |=> (gate_q == rtcco_pkg::GATE_OFF) ##1 !slow_clock_output_pin)
    else $error("clock output not held low when disabled");

  a_disable_reset: assert property (@(posedge ref_clk)
    $past(!rst_n) && rst_n |-> !clock_out_disable_a && !clock_out_disable_b)
    else $error("disable bits not zero after reset");

  a_gate_sync: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(gate_q) |-> $past(xtalFall) && !$past(xtalS))
    else $error("clock gate changed outside crystal falling edge");

  a_power_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    strapTake |=> power_from_zero_flag == !$past(batteryS))
    else $error("power-from-zero flag wrong after strap capture");

  a_seconds_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    secondsWrite |=> prescale_q == '0 ##1 !secondTick)
    else $error("prescaler not cleared by seconds write");

  a_level_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    period_select[2] && periodic_irq_flag && !periodicFlagClear && $stable(period_select)
    |=> periodic_irq_flag && irqOutAOe)
    else $error("level irq released without flag clear");

  a_level_second: assert property (@(posedge ref_clk) disable iff (!rst_n)
    period_select == rtcco_pkg::PSEL_LEVEL_SEC && secondTick |=> periodic_irq_flag)
    else $error("second period did not set the flag");

endmodule : rtcco_top

// ### testbench/rtcco_host_model.sv
// rtcco_host_model: host side that services the periodic irq and the power flag
// assumes irqActive high while the irq pin is pulled low; pulses last one ref_clk cycle
`timescale 1ns/1ps
module rtcco_host_model #(
  parameter int WAIT_CYCLES = 50,
  parameter int SERVICE_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic irqActive,
  input wire logic levelMode,
  input wire logic power_from_zero_flag,
  output logic periodicFlagClear,
  output logic powerFlagClear
);
  int waitCnt;
  int svcCnt;
  // ----------------------------------------------------------------
  // service loop
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      waitCnt <= 0;
      svcCnt <= 0;
      periodicFlagClear <= 1'h0;
      powerFlagClear <= 1'h0;
    end else if (waitCnt < WAIT_CYCLES) begin
      waitCnt <= waitCnt + 1;
      periodicFlagClear <= 1'h0;
      powerFlagClear <= 1'h0;
    end else begin
      powerFlagClear <= power_from_zero_flag && !powerFlagClear;
      // pulse modes are never acknowledged, only level mode holds a flag
      if (irqActive && levelMode && !periodicFlagClear) begin
        // whole counter read, first one full, ends inside the service window
        svcCnt <= (svcCnt == SERVICE_CYCLES) ? 0 : svcCnt + 1;
        periodicFlagClear <= (svcCnt == SERVICE_CYCLES);
      end else begin
        svcCnt <= 0;
        periodicFlagClear <= 1'h0;
      end
    end
  end
endmodule : rtcco_host_model

// ### testbench/test_rtcco_top.sv
// test_rtcco_top: self-checking bench for the gated slow clock and periodic irq
// assumes the crystal runs free at 80 ns; outputs settle 1 ns after a ref_clk edge
`timescale 1ns/1ps
module test_rtcco_top;
  typedef struct {int sel; logic val;} rtcco_note_s;
  logic ref_clk = 1'h0, rst_n = 1'h0, xtalClk = 1'h0, pin = 1'h0, disableWrite = 1'h0;
  logic disA = 1'h0, disB = 1'h0, secondsWrite = 1'h0, batteryRestored = 1'h0;
  logic [2:0] period_select = 3'h0;
  rtcco_pkg::rtcco_events_s calEvents = 3'h0;
  logic slowOut, irqA, irqOe, pFlag, pzFlag, dA, dB, secTick, pClear, pzClear;
  logic [31:0] rng = 32'hCE6B4CD0;
  logic [2:0] match;
  int n_mismatch = 0, checks = 0, edgeCnt = 0, edgeStart = 0, highRun = 0;
  rtcco_note_s expQ[$];
  rtcco_note_s n;
  event resultReady;

  rtcco_top rtcco_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .xtalClk(xtalClk),
    .clock_out_control_pin(pin), .disableWrite(disableWrite), .clockOutDisableAIn(disA),
    .clockOutDisableBIn(disB), .secondsWrite(secondsWrite), .period_select(period_select),
    .periodicFlagClear(pClear), .calEvents(calEvents), .batteryRestored(batteryRestored),
    .powerFlagClear(pzClear), .slow_clock_output_pin(slowOut), .irq_out_a(irqA), .irqOutAOe(irqOe),
    .periodic_irq_flag(pFlag), .power_from_zero_flag(pzFlag), .clock_out_disable_a(dA),
    .clock_out_disable_b(dB), .secondTick(secTick));
  rtcco_host_model rtcco_host_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .irqActive(irqOe),
    .levelMode(period_select[2]), .power_from_zero_flag(pzFlag), .periodicFlagClear(pClear),
    .powerFlagClear(pzClear));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #3;
    forever #40 xtalClk = ~xtalClk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic check(input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %b expected %b", $time, seen, exp);
    end
  endtask : check
  task automatic note(input int sel, input logic v);
    expQ.push_back('{sel, v});
  endtask : note
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : cyc
  task automatic print_verdict();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic do_reset(input logic batt);
    @(posedge ref_clk);
    rst_n <= 1'h0;
    batteryRestored <= batt;
    cyc(8);
    rst_n <= 1'h1;
    cyc(5);
    note(3, ~batt);
    note(4, 1'h0);
    note(5, 1'h0);
    ->resultReady;
  endtask : do_reset

  // ----------------------------------------------------------------
  // output watchers
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (slowOut === 1'h1) begin
      highRun <= highRun + 1;
      if (highRun == 0) edgeCnt <= edgeCnt + 1;
    end else begin
      if (highRun > 0) check(highRun >= 3, 1'h1);
      highRun <= 0;
    end
  end
  initial begin
    forever begin
      @(resultReady);
      #1;
      while (expQ.size() > 0) begin
        n = expQ.pop_front();
        case (n.sel)
          0: check((edgeCnt - edgeStart) > 0, n.val);
          1: check(irqOe, n.val);
          2: check(pFlag, n.val);
          3: check(pzFlag, n.val);
          4: check(dA, n.val);
          5: check(dB, n.val);
          6: check(irqA, n.val);
          default: check(secTick, n.val);
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int k;
    do_reset(1'h0);
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      @(posedge ref_clk);
      disableWrite <= 1'h1;
      disA <= i[0];
      disB <= i[1];
      pin <= i[2];
      @(posedge ref_clk);
      disableWrite <= 1'h0;
      cyc(30 + int'(rng[3:0]));
      note(4, i[0]);
      note(5, i[1]);
      edgeStart = edgeCnt;
      cyc(100);
      note(0, i[2] & ~(i[0] & i[1]));
      ->resultReady;
    end
    note(3, 1'h0);
    for (int c = 0; c < 4; c++) begin
      @(posedge ref_clk);
      period_select <= 3'(c);
      secondsWrite <= 1'h1;
      @(posedge ref_clk);
      secondsWrite <= 1'h0;
      cyc(4);
      note(1, c != 0);
      note(6, 1'h0);
      note(7, 1'h0);
      ->resultReady;
    end
    for (int c = 5; c < 8; c++) begin
      rng = xs(rng);
      match = 3'h1 << (7 - c);
      @(posedge ref_clk);
      period_select <= 3'(c);
      cyc(2 + int'(rng[2:0]));
      calEvents <= {match[0], match[2:1]};
      @(posedge ref_clk);
      calEvents <= 3'h0;
      cyc(3);
      note(2, 1'h0);
      ->resultReady;
      calEvents <= match;
      @(posedge ref_clk);
      calEvents <= 3'h0;
      cyc(3);
      note(2, 1'h1);
      note(1, 1'h1);
      ->resultReady;
      for (k = 0; k < 100 && irqOe !== 1'h0; k++) @(posedge ref_clk);
      if (k == 100) begin
        n_mismatch++;
        print_verdict();
      end
      note(2, 1'h0);
      ->resultReady;
    end
    do_reset(1'h1);
    cyc(3);
    print_verdict();
  end
endmodule : test_rtcco_top
